// ### rtl/pds_presence_detect_storage.sv
// Presence-detect storage: two-wire bus slave with fixed module contents.
// Assumes SCL and SDA arrive synchronous to i_clk and the data line is
// pulled up outside; the block only ever pulls it low.
// The straps on i_cfg and i_module_select must stay static while the bus
// is in use, since the contents follow them combinationally.
// Writes are acknowledged but never stored; they only cost the busy time.
// Reads past location 31 return zero; the location wraps at 255.
// Limitation: no glitch filter on the bus lines, so a pulse that lasts a
// single clock is taken as a real level.
//
// Functional notes
// RQ1: Write cycle ends within ten milliseconds.
// RQ2: Busy: bus ignored, line released, no acknowledge.
// RQ3: Location 0 reads 0x80.
// RQ4: Location 1 reads 0x08.
// RQ5: Row, column, density bytes follow density.
// RQ6: Memory type 0x07, one rank 0x01.
// RQ7: Data width 0x48 then 0x00.
// RQ8: Voltage 0x04, configuration type 0x02.
// RQ9: Cycle time, latency 2.5, per grade.
// RQ10: Access time, latency 2.5, per grade.
// RQ11: Component and check widths read 0x08.
// RQ12: Column access delay reads 0x01.
// RQ13: Bursts 0x0E, banks 0x04.
// RQ14: Attributes 0x24, latencies 0x0C, 0x01, 0x02.
// RQ15: General attributes 0x00 or 0xC0 by density.
// RQ16: Cycle time, latency 2, per grade.
// RQ17: Access time, latency 2, per grade.
// RQ18: Latency 1.5 timing bytes read zero.
// RQ19: Row precharge time per grade.
// RQ20: Bank activate spacing per grade.
// RQ21: Activate to column delay per grade.
// RQ22: Row active width per grade.
// RQ23: Answer only select 1010 plus module bits.
// RQ24: Send while acknowledged; else await stop.
// RQ25: Quarter-nanosecond row timing; unlisted locations zero.
module pds_presence_detect_storage #(
  // Clocks of the internal write cycle; shorten it in simulation
  parameter int WRITE_CYCLES = pds_pkg::WRITE_CYCLE_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  input  wire logic [2:0]        i_module_select,
  input  wire pds_pkg::pds_cfg_t i_cfg,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  output logic                   o_write_busy
);

  // Wide enough for the longest write cycle count
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  // Sequencer, bus history and byte handling
  pds_pkg::pds_state_t state_reg;
  logic                scl_reg;
  logic                sda_reg;
  logic [2:0]          bit_cnt_reg;
  logic [2:0]          tx_cnt_reg;
  logic                byte_done_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          tx_reg;
  logic [7:0]          addr_reg;
  logic                read_reg;
  logic                wrote_reg;
  logic                ack_seen_reg;
  logic [7:0]          rom_next;
  // Write cycle
  logic [CNT_W-1:0]    busy_cnt_reg;

  // Decoded bus events
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic busy_done;
  logic sel_match;
  logic rx_state;

  // Fixed contents by location, density and speed grade
  function automatic logic [7:0] rom_byte(
    input logic [7:0]        a,
    input pds_pkg::pds_cfg_t c
  );
    logic [1:0] d;
    logic [1:0] s;
    // Density code 3 reads as the largest build
    d = (c.density == 2'h3) ? 2'h2 : c.density;
    s = c.speed;
    // Locations not decoded below fall through to zero
    rom_byte = pds_pkg::VAL_UNLISTED; // RQ25
    if (a == pds_pkg::OFF_BYTES_USED) begin
      rom_byte = pds_pkg::VAL_BYTES_USED; // RQ3
    end else if (a == pds_pkg::OFF_TOTAL_SIZE) begin
      rom_byte = pds_pkg::VAL_TOTAL_SIZE; // RQ4
    end else if (a == pds_pkg::OFF_MEM_TYPE) begin
      rom_byte = pds_pkg::VAL_MEM_TYPE; // RQ6
    end else if (a == pds_pkg::OFF_ROW_ADDR) begin
      rom_byte = pds_pkg::VAL_ROW_ADDR[d]; // RQ5
    end else if (a == pds_pkg::OFF_COL_ADDR) begin
      rom_byte = pds_pkg::VAL_COL_ADDR[d]; // RQ5
    end else if (a == pds_pkg::OFF_RANKS) begin
      rom_byte = pds_pkg::VAL_RANKS; // RQ6
    end else if (a == pds_pkg::OFF_WIDTH_LOW) begin
      rom_byte = pds_pkg::VAL_WIDTH_LOW; // RQ7
    end else if (a == pds_pkg::OFF_WIDTH_HIGH) begin
      rom_byte = pds_pkg::VAL_WIDTH_HIGH; // RQ7
    end else if (a == pds_pkg::OFF_VOLTAGE) begin
      rom_byte = pds_pkg::VAL_VOLTAGE; // RQ8
    end else if (a == pds_pkg::OFF_CYC_CL25) begin
      rom_byte = pds_pkg::VAL_CYC_CL25[s]; // RQ9
    end else if (a == pds_pkg::OFF_ACC_CL25) begin
      rom_byte = pds_pkg::VAL_ACC_CL25[s]; // RQ10
    end else if (a == pds_pkg::OFF_CONFIG_TYPE) begin
      rom_byte = pds_pkg::VAL_CONFIG_TYPE; // RQ8
    end else if (a == pds_pkg::OFF_REFRESH) begin
      rom_byte = pds_pkg::VAL_REFRESH[d];
    end else if (a == pds_pkg::OFF_PRIM_WIDTH) begin
      rom_byte = pds_pkg::VAL_COMP_WIDTH; // RQ11
    end else if (a == pds_pkg::OFF_ECC_WIDTH) begin
      rom_byte = pds_pkg::VAL_COMP_WIDTH; // RQ11
    end else if (a == pds_pkg::OFF_COL_DELAY) begin
      rom_byte = pds_pkg::VAL_COL_DELAY; // RQ12
    end else if (a == pds_pkg::OFF_BURSTS) begin
      rom_byte = pds_pkg::VAL_BURSTS; // RQ13
    end else if (a == pds_pkg::OFF_BANKS) begin
      rom_byte = pds_pkg::VAL_BANKS; // RQ13
    end else if (a == pds_pkg::OFF_READ_LAT) begin
      rom_byte = pds_pkg::VAL_READ_LAT; // RQ14
    end else if (a == pds_pkg::OFF_SEL_LAT) begin
      rom_byte = pds_pkg::VAL_SEL_LAT; // RQ14
    end else if (a == pds_pkg::OFF_WR_LAT) begin
      rom_byte = pds_pkg::VAL_WR_LAT; // RQ14
    end else if (a == pds_pkg::OFF_MOD_ATTR) begin
      rom_byte = pds_pkg::VAL_MOD_ATTR; // RQ14
    end else if (a == pds_pkg::OFF_GEN_ATTR) begin
      rom_byte = pds_pkg::VAL_GEN_ATTR[d]; // RQ15
    end else if (a == pds_pkg::OFF_CYC_CL2) begin
      rom_byte = pds_pkg::VAL_CYC_CL2[s]; // RQ16
    end else if (a == pds_pkg::OFF_ACC_CL2) begin
      rom_byte = pds_pkg::VAL_ACC_CL2[s]; // RQ17
    end else if (a == pds_pkg::OFF_CYC_CL15) begin
      rom_byte = pds_pkg::VAL_UNSUPPORTED; // RQ18
    end else if (a == pds_pkg::OFF_ACC_CL15) begin
      rom_byte = pds_pkg::VAL_UNSUPPORTED; // RQ18
    end else if (a == pds_pkg::OFF_PRECHARGE) begin
      rom_byte = pds_pkg::VAL_PRECHARGE[s]; // RQ19
    end else if (a == pds_pkg::OFF_BANK_SPACING) begin
      rom_byte = pds_pkg::VAL_SPACING[s]; // RQ20
    end else if (a == pds_pkg::OFF_ACT_TO_COL) begin
      rom_byte = pds_pkg::VAL_ACT_COL[s]; // RQ21
    end else if (a == pds_pkg::OFF_ROW_ACTIVE) begin
      rom_byte = pds_pkg::VAL_ROW_ACT[s]; // RQ22
    end else if (a == pds_pkg::OFF_RANK_DENSITY) begin
      rom_byte = pds_pkg::VAL_DENSITY[d]; // RQ5
    end
  endfunction : rom_byte

  // Bus line history for edge and condition detection
  // Reset to the idle high levels, so no false edge follows reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= i_scl;
      sda_reg <= i_sda;
    end
  end

  assign scl_rise   = i_scl & ~scl_reg;
  assign scl_fall   = ~i_scl & scl_reg;
  // Both conditions need SCL high in two samples, so an SDA change on
  // the clock where SCL moves is data, never a start or a stop
  assign start_cond = i_scl & scl_reg & sda_reg & ~i_sda;
  assign stop_cond  = i_scl & scl_reg & ~sda_reg & i_sda;
  assign busy_done  = (busy_cnt_reg == CNT_W'(WRITE_CYCLES - 1));
  // Byte at the current location, loaded as each read byte begins
  assign rom_next   = rom_byte(addr_reg, i_cfg);
  // Select byte carries the storage code and this module's straps
  assign sel_match  = (shift_reg[7:4] == pds_pkg::DEV_ID) &&
                      (shift_reg[3:1] == i_module_select); // RQ23
  // States in which the master sends bits to the block
  assign rx_state   = (state_reg == pds_pkg::ST_DEVSEL) ||
                      (state_reg == pds_pkg::ST_ADDR) ||
                      (state_reg == pds_pkg::ST_WDATA);

  // Write cycle timer; runs only while busy
  // Busy ends when it reaches WRITE_CYCLES - 1, so busy stands WRITE_CYCLES clocks
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_reg <= '0;
    end else if (state_reg == pds_pkg::ST_BUSY) begin
      busy_cnt_reg <= busy_cnt_reg + CNT_W'(1); // RQ1
    end else begin
      busy_cnt_reg <= '0;
    end
  end

  // Incoming bits are taken on SCL rising edges
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
    end else if (start_cond) begin
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
    end else if (scl_rise) begin
      if (rx_state) begin
        shift_reg     <= {shift_reg[6:0], i_sda};
        bit_cnt_reg   <= bit_cnt_reg + 3'h1;
        byte_done_reg <= (bit_cnt_reg == 3'h7);
      end
    end else if (scl_fall && byte_done_reg) begin
      byte_done_reg <= 1'b0;
    end
  end

  // Master acknowledge, taken on the ninth rise of a read byte
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_seen_reg <= 1'b0;
    end else if (scl_rise && state_reg == pds_pkg::ST_RX_ACK) begin
      ack_seen_reg <= ~i_sda; // RQ24
    end
  end

  // Protocol sequencer; the line only changes while SCL is low
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg    <= pds_pkg::ST_IDLE;
      o_sda_oe     <= 1'b0;
      tx_reg       <= 8'h00;
      // Current location starts at zero
      addr_reg     <= 8'h00;
      read_reg     <= 1'b0;
      wrote_reg    <= 1'b0;
    end else if (state_reg == pds_pkg::ST_BUSY) begin
      // The bus is ignored until the timer runs out; the master polls
      // with select bytes that get no acknowledge meanwhile
      o_sda_oe <= 1'b0; // RQ2
      if (busy_done) begin
        state_reg <= pds_pkg::ST_IDLE; // RQ1
      end
    end else if (stop_cond) begin
      o_sda_oe  <= 1'b0;
      wrote_reg <= 1'b0;
      // Contents are fixed; the write only costs the busy time
      state_reg <= wrote_reg ? pds_pkg::ST_BUSY : pds_pkg::ST_IDLE;
    end else if (start_cond) begin
      // Any start outside the write cycle, repeated ones included, begins a new select byte
      o_sda_oe  <= 1'b0;
      state_reg <= pds_pkg::ST_DEVSEL;
    end else if (scl_fall) begin
      // Every step happens on an SCL fall, while SCL is low
      case (state_reg)
        // Acknowledge only a matching select byte
        pds_pkg::ST_DEVSEL: begin
          if (byte_done_reg) begin
            if (sel_match) begin
              o_sda_oe  <= 1'b1; // RQ23
              read_reg  <= shift_reg[0];
              state_reg <= pds_pkg::ST_ACK_DEV;
            end else begin
              state_reg <= pds_pkg::ST_IDLE; // RQ23
            end
          end
        end
        // End of the select acknowledge: a read puts out bit 7 of the
        // current byte, a write goes on to the address byte
        pds_pkg::ST_ACK_DEV: begin
          if (read_reg) begin
            tx_reg    <= rom_next;
            o_sda_oe  <= ~rom_next[7];
            addr_reg  <= addr_reg + 8'h01;
            state_reg <= pds_pkg::ST_TX;
          end else begin
            o_sda_oe  <= 1'b0;
            state_reg <= pds_pkg::ST_ADDR;
          end
        end
        // Address byte sets the current location
        pds_pkg::ST_ADDR: begin
          if (byte_done_reg) begin
            addr_reg  <= shift_reg;
            o_sda_oe  <= 1'b1;
            state_reg <= pds_pkg::ST_ACK_ADDR;
          end
        end
        // Acknowledge ends; data bytes or a restart follow
        pds_pkg::ST_ACK_ADDR: begin
          o_sda_oe  <= 1'b0;
          state_reg <= pds_pkg::ST_WDATA;
        end
        // Data is acknowledged and dropped; only the location moves on
        pds_pkg::ST_WDATA: begin
          if (byte_done_reg) begin
            o_sda_oe  <= 1'b1;
            wrote_reg <= 1'b1;
            addr_reg  <= addr_reg + 8'h01;
            state_reg <= pds_pkg::ST_ACK_WDATA;
          end
        end
        // Acknowledge ends; the master may send another byte
        pds_pkg::ST_ACK_WDATA: begin
          o_sda_oe  <= 1'b0;
          state_reg <= pds_pkg::ST_WDATA;
        end
        // Eight bits out, top bit first, then release for the master
        pds_pkg::ST_TX: begin
          if (tx_cnt_reg == 3'h7) begin
            o_sda_oe    <= 1'b0;
            state_reg   <= pds_pkg::ST_RX_ACK;
          end else begin
            tx_reg   <= {tx_reg[6:0], 1'b0};
            o_sda_oe <= ~tx_reg[6];
          end
        end
        // Acknowledged: next byte; otherwise stay off until a stop
        pds_pkg::ST_RX_ACK: begin
          if (ack_seen_reg) begin
            tx_reg    <= rom_next; // RQ24
            o_sda_oe  <= ~rom_next[7];
            addr_reg  <= addr_reg + 8'h01;
            state_reg <= pds_pkg::ST_TX;
          end else begin
            state_reg <= pds_pkg::ST_WAIT_STOP; // RQ24
          end
        end
        // Idle and waiting for a stop keep the line released
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Transmit bit count, separate from the receive count; it clears
  // outside a read byte, so each byte starts at its top bit
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_cnt_reg <= 3'h0;
    end else if (state_reg != pds_pkg::ST_TX) begin
      tx_cnt_reg <= 3'h0;
    end else if (scl_fall) begin
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
    end
  end

  // Constant low: with the enable this makes an open-drain data pin
  // whose high level comes from the outside pull-up
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sda_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
    end
  end

  // Busy rises with the stop that ends a write
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_write_busy <= 1'b0;
    end else begin
      o_write_busy <= (state_reg == pds_pkg::ST_BUSY) ? ~busy_done
                      : (stop_cond && wrote_reg); // RQ2
    end
  end

endmodule : pds_presence_detect_storage

// ### rtl/pds_pkg.sv
// Constants and types for the presence-detect storage block.
// Assumes a 20 MHz system clock; the two-wire bus pins arrive synchronous.
package pds_pkg;

  // System clock and write cycle timing
  localparam int CLK_HZ             = 20_000_000;
  localparam int WRITE_CYCLE_MS     = 10;
  // Longest time, so rounded down to whole cycles
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * (CLK_HZ / 1000);

  // Select byte: device identifier in the top four bits
  localparam logic [3:0] DEV_ID     = 4'hA;

  // Location offsets
  localparam logic [7:0] OFF_BYTES_USED   = 8'h00;
  localparam logic [7:0] OFF_TOTAL_SIZE   = 8'h01;
  localparam logic [7:0] OFF_MEM_TYPE     = 8'h02;
  localparam logic [7:0] OFF_ROW_ADDR     = 8'h03;
  localparam logic [7:0] OFF_COL_ADDR     = 8'h04;
  localparam logic [7:0] OFF_RANKS        = 8'h05;
  localparam logic [7:0] OFF_WIDTH_LOW    = 8'h06;
  localparam logic [7:0] OFF_WIDTH_HIGH   = 8'h07;
  localparam logic [7:0] OFF_VOLTAGE      = 8'h08;
  localparam logic [7:0] OFF_CYC_CL25     = 8'h09;
  localparam logic [7:0] OFF_ACC_CL25     = 8'h0A;
  localparam logic [7:0] OFF_CONFIG_TYPE  = 8'h0B;
  localparam logic [7:0] OFF_REFRESH      = 8'h0C;
  localparam logic [7:0] OFF_PRIM_WIDTH   = 8'h0D;
  localparam logic [7:0] OFF_ECC_WIDTH    = 8'h0E;
  localparam logic [7:0] OFF_COL_DELAY    = 8'h0F;
  localparam logic [7:0] OFF_BURSTS       = 8'h10;
  localparam logic [7:0] OFF_BANKS        = 8'h11;
  localparam logic [7:0] OFF_READ_LAT     = 8'h12;
  localparam logic [7:0] OFF_SEL_LAT      = 8'h13;
  localparam logic [7:0] OFF_WR_LAT       = 8'h14;
  localparam logic [7:0] OFF_MOD_ATTR     = 8'h15;
  localparam logic [7:0] OFF_GEN_ATTR     = 8'h16;
  localparam logic [7:0] OFF_CYC_CL2      = 8'h17;
  localparam logic [7:0] OFF_ACC_CL2      = 8'h18;
  localparam logic [7:0] OFF_CYC_CL15     = 8'h19;
  localparam logic [7:0] OFF_ACC_CL15     = 8'h1A;
  localparam logic [7:0] OFF_PRECHARGE    = 8'h1B;
  localparam logic [7:0] OFF_BANK_SPACING = 8'h1C;
  localparam logic [7:0] OFF_ACT_TO_COL   = 8'h1D;
  localparam logic [7:0] OFF_ROW_ACTIVE   = 8'h1E;
  localparam logic [7:0] OFF_RANK_DENSITY = 8'h1F;

  // Fixed contents
  localparam logic [7:0] VAL_BYTES_USED  = 8'h80;
  localparam logic [7:0] VAL_TOTAL_SIZE  = 8'h08;
  localparam logic [7:0] VAL_MEM_TYPE    = 8'h07;
  localparam logic [7:0] VAL_RANKS       = 8'h01;
  localparam logic [7:0] VAL_WIDTH_LOW   = 8'h48;
  localparam logic [7:0] VAL_WIDTH_HIGH  = 8'h00;
  localparam logic [7:0] VAL_VOLTAGE     = 8'h04;
  localparam logic [7:0] VAL_CONFIG_TYPE = 8'h02;
  localparam logic [7:0] VAL_COMP_WIDTH  = 8'h08;
  localparam logic [7:0] VAL_COL_DELAY   = 8'h01;
  localparam logic [7:0] VAL_BURSTS      = 8'h0E;
  localparam logic [7:0] VAL_BANKS       = 8'h04;
  localparam logic [7:0] VAL_READ_LAT    = 8'h0C;
  localparam logic [7:0] VAL_SEL_LAT     = 8'h01;
  localparam logic [7:0] VAL_WR_LAT      = 8'h02;
  localparam logic [7:0] VAL_MOD_ATTR    = 8'h24;
  localparam logic [7:0] VAL_UNSUPPORTED = 8'h00;
  localparam logic [7:0] VAL_UNLISTED    = 8'h00;

  // Density-indexed contents, index 0 smallest .. 2 largest
  localparam logic [2:0][7:0] VAL_ROW_ADDR  = {8'h0D, 8'h0D, 8'h0C};
  localparam logic [2:0][7:0] VAL_COL_ADDR  = {8'h0B, 8'h0A, 8'h0A};
  localparam logic [2:0][7:0] VAL_REFRESH   = {8'h82, 8'h82, 8'h80};
  localparam logic [2:0][7:0] VAL_GEN_ATTR  = {8'hC0, 8'hC0, 8'h00};
  localparam logic [2:0][7:0] VAL_DENSITY   = {8'h80, 8'h40, 8'h20};

  // Speed-indexed contents, index 0 fastest .. 3 slowest
  localparam logic [3:0][7:0] VAL_CYC_CL25  = {8'h75, 8'h70, 8'h70, 8'h60};
  localparam logic [3:0][7:0] VAL_ACC_CL25  = {8'h75, 8'h75, 8'h75, 8'h70};
  localparam logic [3:0][7:0] VAL_CYC_CL2   = {8'hA0, 8'h75, 8'h75, 8'h75};
  localparam logic [3:0][7:0] VAL_ACC_CL2   = {8'h75, 8'h75, 8'h75, 8'h70};
  localparam logic [3:0][7:0] VAL_PRECHARGE = {8'h50, 8'h50, 8'h3C, 8'h48};
  localparam logic [3:0][7:0] VAL_SPACING   = {8'h3C, 8'h3C, 8'h3C, 8'h30};
  localparam logic [3:0][7:0] VAL_ACT_COL   = {8'h50, 8'h50, 8'h3C, 8'h48};
  localparam logic [3:0][7:0] VAL_ROW_ACT   = {8'h2D, 8'h2D, 8'h2D, 8'h2A};

  // Module build straps
  typedef struct packed {
    logic [1:0] density;
    logic [1:0] speed;
  } pds_cfg_t;

  // Gray codes along the write path
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_DEVSEL    = 4'h1,
    ST_ACK_DEV   = 4'h3,
    ST_ADDR      = 4'h2,
    ST_ACK_ADDR  = 4'h6,
    ST_WDATA     = 4'h7,
    ST_ACK_WDATA = 4'h5,
    ST_TX        = 4'h4,
    ST_RX_ACK    = 4'hC,
    ST_WAIT_STOP = 4'hD,
    ST_BUSY      = 4'hF
  } pds_state_t;

endpackage : pds_pkg

// ### verification/pds_presence_detect_storage_checker.sv
// Port checker for the presence-detect storage block.
// Assumes the bus pins are synchronous to i_clk; bound to every instance.
module pds_presence_detect_storage_checker #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic              i_scl,
  input wire logic              i_sda,
  input wire logic [2:0]        i_module_select,
  input wire pds_pkg::pds_cfg_t i_cfg,
  input wire logic              o_sda_out,
  input wire logic              o_sda_oe,
  input wire logic              o_write_busy
);
  int busy_cnt_reg;

  // Counts consecutive busy clocks so the bound needs no long repetition
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_reg <= 0;
    end else begin
      busy_cnt_reg <= o_write_busy ? busy_cnt_reg + 1 : 0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_busy_no_drive: assert property (o_write_busy |-> !o_sda_oe)
    else $error("data line pulled during write cycle");
  a_drive_is_low: assert property (o_sda_oe |-> !o_sda_out)
    else $error("data line driven high");
  a_busy_max_len: assert property (busy_cnt_reg <= WRITE_CYCLES)
    else $error("write cycle too long");
  a_busy_exact_len: assert property (
    $fell(o_write_busy) |-> busy_cnt_reg == WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_after_stop: assert property (
    $rose(o_write_busy) |-> $past(i_scl) && $past(i_sda))
    else $error("write cycle began without stop");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while bus clock high");
  a_start_quiet: assert property (
    i_scl && $past(i_scl) && $fell(i_sda) |=> !o_sda_oe [*8])
    else $error("data line driven during select byte");
  a_ack_not_busy: assert property (
    $rose(o_sda_oe) |-> !o_write_busy && !$past(o_write_busy))
    else $error("answer given around write cycle");
  a_reset_idle: assert property (
    $rose(i_nrst) |-> !o_sda_oe && !o_write_busy)
    else $error("outputs active after reset");

  c_busy_start: cover property ($rose(o_write_busy));
  c_busy_end: cover property ($fell(o_write_busy));
  c_drive: cover property ($rose(o_sda_oe));
  c_start: cover property (i_scl && $past(i_scl) && $fell(i_sda));
endmodule : pds_presence_detect_storage_checker

bind pds_presence_detect_storage pds_presence_detect_storage_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda),
  .i_module_select(i_module_select), .i_cfg(i_cfg),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_write_busy(o_write_busy)
);

// ### verification/pds_host_model.sv
// Two-wire bus master model driving the bus clock and pulling data low.
// Assumes the bench resolves the data wire with a pull-up.
module pds_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4;

  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // Also serves as repeated start from a low bus clock
  task automatic start_cond();
    o_sda_oe = 1'b0;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_oe = 1'b1;
    tick(HALF);
    o_scl = 1'b0;
    tick(1);
  endtask : start_cond

  task automatic stop_cond();
    o_sda_oe = 1'b1;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_oe = 1'b0;
    tick(2 * HALF);
  endtask : stop_cond

  // Data held one clock past the fall to keep hold time
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe = !b;
    tick(HALF);
    o_scl = 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl = 1'b0;
    tick(1);
  endtask : bit_io

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask : recv_byte
endmodule : pds_host_model

// ### verification/pds_presence_detect_storage_tb.sv
// Self-checking bench: reads locations 0 to 32 for each of the 16 builds, writes, probes busy.
// Assumes a pulled-up data wire shared by the host model and the block.
module pds_presence_detect_storage_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         WCYC = 200;
  localparam logic [2:0] MSEL = 3'h5;

  logic              i_clk, i_nrst, scl, sda, host_oe;
  logic              o_sda_out, o_sda_oe, o_write_busy, ack;
  logic [7:0]        b;
  pds_pkg::pds_cfg_t cfg;
  int                failures, n_tests;

  assign sda = ~host_oe & ~(o_sda_oe & ~o_sda_out);
  always #25 i_clk = ~i_clk;

  pds_presence_detect_storage #(.WRITE_CYCLES(WCYC)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
    .i_module_select(MSEL), .i_cfg(cfg), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_write_busy(o_write_busy));

  pds_host_model u_host (
    .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

  function automatic logic [7:0] exp_byte(input logic [7:0] a,
                                          input logic [1:0] d, s);
    case (a)
      8'h00: return 8'h80;
      8'h01: return 8'h08;
      8'h02: return 8'h07;
      8'h03: return d == 2'h0 ? 8'h0C : 8'h0D;
      8'h04: return d[1] ? 8'h0B : 8'h0A;
      8'h05: return 8'h01;
      8'h06: return 8'h48;
      8'h07: return 8'h00;
      8'h08: return 8'h04;
      8'h09: return s == 2'h0 ? 8'h60 : (s == 2'h3 ? 8'h75 : 8'h70);
      8'h0A: return s == 2'h0 ? 8'h70 : 8'h75;
      8'h0B: return 8'h02;
      8'h0C: return d == 2'h0 ? 8'h80 : 8'h82;
      8'h0D, 8'h0E: return 8'h08;
      8'h0F: return 8'h01;
      8'h10: return 8'h0E;
      8'h11: return 8'h04;
      8'h12: return 8'h0C;
      8'h13: return 8'h01;
      8'h14: return 8'h02;
      8'h15: return 8'h24;
      8'h16: return d == 2'h0 ? 8'h00 : 8'hC0;
      8'h17: return s == 2'h3 ? 8'hA0 : 8'h75;
      8'h18: return s == 2'h0 ? 8'h70 : 8'h75;
      8'h1B, 8'h1D: return s == 2'h0 ? 8'h48 :
                           (s == 2'h1 ? 8'h3C : 8'h50);
      8'h1C: return s == 2'h0 ? 8'h30 : 8'h3C;
      8'h1E: return s == 2'h0 ? 8'h2A : 8'h2D;
      8'h1F: return d == 2'h0 ? 8'h20 : (d == 2'h1 ? 8'h40 : 8'h80);
      default: return 8'h00;
    endcase
  endfunction : exp_byte

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen 0x%0h expected 0x%0h",
               $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic select(input logic [3:0] id, input logic rw,
                        input logic exp_ack);
    u_host.start_cond();
    u_host.send_byte({id, MSEL, rw}, ack);
    check({7'h0, ack}, {7'h0, exp_ack});
  endtask : select

  // Random read then sequential read; last byte is not acknowledged
  task automatic rd_seq(input logic [7:0] a, input int n);
    select(4'hA, 1'b0, 1'b1);
    u_host.send_byte(a, ack);
    check({7'h0, ack}, 8'h01);
    select(4'hA, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_host.recv_byte(b, i < n - 1);
      check(b, exp_byte(a + i[7:0], cfg.density, cfg.speed));
    end
    u_host.stop_cond();
  endtask : rd_seq

  initial begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    cfg = '0;
    failures = 0;
    n_tests = 0;
    repeat (8) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    u_host.tick(2);
    check({6'h0, o_sda_oe, o_write_busy}, 8'h00);
    for (int d = 0; d < 4; d++) begin
      for (int s = 0; s < 4; s++) begin
        cfg.density = d[1:0];
        cfg.speed = s[1:0];
        rd_seq(8'h00, 33);
      end
    end
    // Address wraps from the top location back to zero
    rd_seq(8'hFF, 2);
    // Wrong module bits and the other device code get no answer
    select(4'hA, {1'b0}, 1'b1);
    u_host.stop_cond();
    u_host.start_cond();
    u_host.send_byte({4'hA, MSEL ^ 3'h2, 1'b1}, ack);
    check({7'h0, ack}, 8'h00);
    select(4'h6, 1'b1, 1'b0);
    u_host.stop_cond();
    // After a refused byte the block stays off the line
    select(4'hA, 1'b1, 1'b1);
    u_host.recv_byte(b, 1'b0);
    u_host.recv_byte(b, 1'b0);
    check(b, 8'hFF);
    u_host.stop_cond();
    // Write one byte: acked, starts the write cycle, content unchanged
    select(4'hA, 1'b0, 1'b1);
    u_host.send_byte(8'h03, ack);
    check({7'h0, ack}, 8'h01);
    u_host.send_byte(8'h55, ack);
    check({7'h0, ack}, 8'h01);
    u_host.stop_cond();
    check({7'h0, o_write_busy}, 8'h01);
    select(4'hA, 1'b1, 1'b0);
    u_host.stop_cond();
    for (int i = 0; o_write_busy !== 1'b0; i++) begin
      if (i > WCYC) begin
        failures++;
        stop_test();
      end
      u_host.tick(1);
    end
    rd_seq(8'h03, 1);
    stop_test();
  end
endmodule : pds_presence_detect_storage_tb
